// [sx_exec_unit.sv]
`timescale 1ns/1ns
module sx_exec_unit
  import sx_pkg::*;
#(
  parameter bit XORI_ZERO_EXT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_wr,
  output logic [0:31] mem_addr,
  output logic [0:31] mem_wdata,
  output logic [0:3] mem_be,
  output logic dcache_wr,
  output logic icache_wr,
  output logic [0:31] cache_tag,
  output logic cache_valid,
  output logic cache_lock,
  output logic [0:31] cache_data
);
  sx_state_t st_q, st_d;
  sx_op_t op_q, op_d;
  logic [0:31] first_q, first_d, second_q, second_d, stdata_q, stdata_d;
  logic [0:15] imm_q, imm_d, prefix_q, prefix_d;
  logic pfx_q, pfx_d;
  logic [0:31] result_q, result_d;
  logic [2:0] mach_q, mach_d;
  logic err_q, err_d, err_set, err_clr;
  logic [31:0] prdata_q, prdata_d, rd_mux;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic mem_wr_q, mem_wr_d, dc_wr_q, dc_wr_d, ic_wr_q, ic_wr_d;
  logic [0:31] mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;
  logic [0:3] mem_be_q, mem_be_d;
  logic [0:31] ctag_q, ctag_d, cdata_q, cdata_d;
  logic busy, hit, wr_ok, is_half, is_imm, is_store;
  logic [0:31] imm_ext, xor_imm, st_addr, st_wdata, alu_res;
  logic [0:3] st_be;
  logic alu_cout;

  assign busy = (st_q != ST_IDLE);
  assign wr_ok = psel && penable && pready_q && pwrite && !pslverr_q;
  assign is_half = (op_q == OP_STORE_HALF_REG) || (op_q == OP_STORE_HALF_IMM);
  assign is_imm = (op_q == OP_STORE_HALF_IMM) || (op_q == OP_STORE_WORD_IMM);
  assign is_store = is_half || is_imm || (op_q == OP_STORE_WORD_REG);

  assign imm_ext = pfx_q ? {prefix_q, imm_q} : {{IMM_W{imm_q[0]}}, imm_q};
  assign xor_imm = (XORI_ZERO_EXT && !pfx_q) ? {HALF_RST, imm_q} : imm_ext;

  sx_store_addr u_store (
    .half(is_half),
    .use_imm(is_imm),
    .base(first_q),
    .index(second_q),
    .imm_ext(imm_ext),
    .data(stdata_q),
    .addr(st_addr),
    .wdata(st_wdata),
    .be(st_be)
  );

  sx_shift_xor u_alu (
    .op(op_q),
    .a(first_q),
    .b(second_q),
    .imm_ext(xor_imm),
    .carry_in(mach_q[MACH_CARRY_BIT]),
    .res(alu_res),
    .cout(alu_cout)
  );

  always_comb begin
    hit = 1'b1;
    rd_mux = WORD_RST;
    case (paddr)
      OFS_CTRL: rd_mux = {22'h0, pfx_q, 1'b0, 4'h0, op_q};
      OFS_FIRST: rd_mux = first_q;
      OFS_SECOND: rd_mux = second_q;
      OFS_STDATA: rd_mux = stdata_q;
      OFS_IMM: rd_mux = {HALF_RST, imm_q};
      OFS_PREFIX: rd_mux = {HALF_RST, prefix_q};
      OFS_RESULT: rd_mux = result_q;
      OFS_MACH: rd_mux = {29'h0, mach_q};
      OFS_STATUS: rd_mux = {30'h0, err_q, busy};
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    first_d = first_q;
    second_d = second_q;
    stdata_d = stdata_q;
    imm_d = imm_q;
    prefix_d = prefix_q;
    pfx_d = pfx_q;
    result_d = result_q;
    mach_d = mach_q;
    err_set = 1'b0;
    err_clr = 1'b0;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    mem_be_d = mem_be_q;
    dc_wr_d = 1'b0;
    ic_wr_d = 1'b0;
    ctag_d = ctag_q;
    cdata_d = cdata_q;
    // one wait state keeps every bus output registered
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      pslverr_d = !hit || (pwrite && busy);
      prdata_d = rd_mux;
    end
    // operands are frozen while busy, so writes then are refused
    if (wr_ok) begin
      case (paddr)
        OFS_CTRL: begin
          pfx_d = pwdata[CTRL_PFX_BIT];
          if (pwdata[CTRL_GO_BIT]) begin
            if (pwdata[CTRL_OP_LSB +: CTRL_OP_W] > OP_ICACHE_WR) begin
              err_set = 1'b1;
            end else begin
              op_d = sx_op_t'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
              st_d = ST_EXEC;
            end
          end
        end
        OFS_FIRST: first_d = pwdata;
        OFS_SECOND: second_d = pwdata;
        OFS_STDATA: stdata_d = pwdata;
        OFS_IMM: imm_d = pwdata[15:0];
        OFS_PREFIX: prefix_d = pwdata[15:0];
        OFS_MACH: mach_d = pwdata[2:0];
        OFS_STATUS: err_clr = pwdata[STAT_ERR_BIT];
        default: ;
      endcase
    end
    unique case (st_q)
      ST_IDLE: ;
      ST_EXEC: begin
        // prefix covers only the next instruction
        pfx_d = 1'b0;
        st_d = ST_IDLE;
        unique case (op_q)
          OP_STORE_HALF_REG, OP_STORE_HALF_IMM, OP_STORE_WORD_REG, OP_STORE_WORD_IMM: begin
            st_d = ST_MEM;
            mem_wr_d = 1'b1;
            mem_addr_d = st_addr;
            mem_wdata_d = st_wdata;
            mem_be_d = st_be;
          end
          OP_SHIFT_ARITH, OP_SHIFT_THRU_CARRY, OP_SHIFT_LOGIC: begin
            result_d = alu_res;
            mach_d[MACH_CARRY_BIT] = alu_cout;
          end
          OP_XOR_REG, OP_XOR_IMM: begin
            result_d = alu_res;
          end
          OP_DCACHE_WR: begin
            if (mach_q[MACH_DCE_BIT]) begin
              err_set = 1'b1;
            end else begin
              dc_wr_d = 1'b1;
              ctag_d = first_q;
              cdata_d = second_q;
            end
          end
          OP_ICACHE_WR: begin
            if (mach_q[MACH_ICE_BIT]) begin
              err_set = 1'b1;
            end else begin
              ic_wr_d = 1'b1;
              ctag_d = first_q;
              cdata_d = second_q;
            end
          end
        endcase
      end
      ST_MEM: st_d = ST_IDLE;
    endcase
    // a new error beats a clear in the same cycle
    err_d = err_set || (err_q && !err_clr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      op_q <= OP_STORE_HALF_REG;
      {first_q, second_q, stdata_q, result_q} <= {4{WORD_RST}};
      {imm_q, prefix_q, pfx_q, mach_q, err_q} <= {HALF_RST, HALF_RST, 1'b0, MACH_RST, 1'b0};
      {prdata_q, pready_q, pslverr_q} <= {WORD_RST, 2'b00};
      {mem_wr_q, mem_addr_q, mem_wdata_q, mem_be_q} <= {1'b0, WORD_RST, WORD_RST, 4'h0};
      {dc_wr_q, ic_wr_q, ctag_q, cdata_q} <= {2'b00, WORD_RST, WORD_RST};
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      {first_q, second_q, stdata_q, result_q} <= {first_d, second_d, stdata_d, result_d};
      {imm_q, prefix_q, pfx_q, mach_q, err_q} <= {imm_d, prefix_d, pfx_d, mach_d, err_d};
      {prdata_q, pready_q, pslverr_q} <= {prdata_d, pready_d, pslverr_d};
      {mem_wr_q, mem_addr_q, mem_wdata_q, mem_be_q} <= {mem_wr_d, mem_addr_d, mem_wdata_d, mem_be_d};
      {dc_wr_q, ic_wr_q, ctag_q, cdata_q} <= {dc_wr_d, ic_wr_d, ctag_d, cdata_d};
    end
  end

  assign {prdata, pready, pslverr} = {prdata_q, pready_q, pslverr_q};
  assign {mem_wr, mem_addr, mem_wdata, mem_be} = {mem_wr_q, mem_addr_q, mem_wdata_q, mem_be_q};
  assign {dcache_wr, icache_wr, cache_tag, cache_data} = {dc_wr_q, ic_wr_q, ctag_q, cdata_q};
  assign {cache_valid, cache_lock} = {ctag_q[30], ctag_q[31]};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic exec;
  assign exec = (st_q == ST_EXEC);

  chk_half_reg_store: assert property (
    exec && op_q == OP_STORE_HALF_REG |=> mem_wr_q && mem_wdata_q[16:31] == $past(stdata_q[16:31])
      && mem_addr_q == (($past(first_q) + $past(second_q)) & 32'hFFFF_FFFE) ##1 !mem_wr_q && !busy)
    else $error("halfword register store wrong");
  chk_half_imm_store: assert property (
    exec && op_q == OP_STORE_HALF_IMM |=> mem_wr_q && mem_be_q != BE_ALL
      && mem_addr_q == (($past(first_q) + $past(imm_ext)) & 32'hFFFF_FFFE) ##1 !busy)
    else $error("halfword immediate store wrong");
  chk_word_reg_store: assert property (
    exec && op_q == OP_STORE_WORD_REG |=> mem_wr_q && mem_be_q == BE_ALL && mem_wdata_q == $past(stdata_q)
      && mem_addr_q == (($past(first_q) + $past(second_q)) & 32'hFFFF_FFFC))
    else $error("word register store wrong");
  chk_word_imm_store: assert property (
    exec && op_q == OP_STORE_WORD_IMM |=> mem_wr_q
      && mem_addr_q == (($past(first_q) + $past(imm_ext)) & 32'hFFFF_FFFC))
    else $error("word immediate store wrong");
  chk_imm_extend: assert property (
    imm_ext == (pfx_q ? {prefix_q, imm_q} : {{16{imm_q[0]}}, imm_q}))
    else $error("immediate extension wrong");
  chk_prefix_consumed: assert property (exec |=> !pfx_q)
    else $error("prefix not consumed");
  chk_shift_body: assert property (
    exec && (op_q == OP_SHIFT_ARITH || op_q == OP_SHIFT_THRU_CARRY || op_q == OP_SHIFT_LOGIC)
      |=> result_q[1:31] == $past(first_q[0:30]) && mach_q[MACH_CARRY_BIT] == $past(first_q[31]) && !busy)
    else $error("shift body or carry wrong");
  chk_arith_fill: assert property (exec && op_q == OP_SHIFT_ARITH |=> result_q[0] == $past(first_q[0]))
    else $error("arithmetic shift fill wrong");
  chk_carry_fill: assert property (
    exec && op_q == OP_SHIFT_THRU_CARRY |=> result_q[0] == $past(mach_q[MACH_CARRY_BIT]))
    else $error("carry shift fill wrong");
  chk_logic_fill: assert property (exec && op_q == OP_SHIFT_LOGIC |=> !result_q[0])
    else $error("logical shift fill wrong");
  chk_dcache_write: assert property (
    exec && op_q == OP_DCACHE_WR && !mach_q[MACH_DCE_BIT]
      |=> dcache_wr && !icache_wr && cache_tag == $past(first_q) && cache_data == $past(second_q) ##1 !dcache_wr)
    else $error("data cache write wrong");
  chk_dcache_flags: assert property (
    dcache_wr |-> cache_valid == $past(first_q[30]) && cache_lock == $past(first_q[31]))
    else $error("cache valid or lock wrong");
  chk_dcache_refused: assert property (
    exec && op_q == OP_DCACHE_WR && mach_q[MACH_DCE_BIT] |=> !dcache_wr && err_q)
    else $error("write to enabled data cache taken");
  chk_icache_write: assert property (
    exec && op_q == OP_ICACHE_WR && !mach_q[MACH_ICE_BIT]
      |=> icache_wr && cache_valid == $past(first_q[30]) && cache_data == $past(second_q))
    else $error("instruction cache write wrong");
  chk_xor_reg: assert property (
    exec && op_q == OP_XOR_REG |=> result_q == ($past(first_q) ^ $past(second_q)) && $stable(mach_q))
    else $error("register xor wrong");
  chk_xor_imm: assert property (
    exec && op_q == OP_XOR_IMM |=> result_q == ($past(first_q) ^ $past(xor_imm)) && !busy)
    else $error("immediate xor wrong");
  chk_store_quiet: assert property (
    exec && is_store |=> $stable(result_q) && $stable(mach_q) ##1 $stable(result_q) && $stable(mach_q))
    else $error("store altered result or carry");
endmodule : sx_exec_unit

// [sx_pkg.sv]
package sx_pkg;
  localparam int ADDR_W = 8;
  localparam int IMM_W = 16;

  typedef enum logic [3:0] {
    OP_STORE_HALF_REG,
    OP_STORE_HALF_IMM,
    OP_STORE_WORD_REG,
    OP_STORE_WORD_IMM,
    OP_SHIFT_ARITH,
    OP_SHIFT_THRU_CARRY,
    OP_SHIFT_LOGIC,
    OP_XOR_REG,
    OP_XOR_IMM,
    OP_DCACHE_WR,
    OP_ICACHE_WR
  } sx_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_MEM} sx_state_t;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FIRST = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SECOND = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STDATA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IMM = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PREFIX = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MACH = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 4;
  localparam int CTRL_GO_BIT = 8;
  localparam int CTRL_PFX_BIT = 9;
  localparam int MACH_CARRY_BIT = 0;
  localparam int MACH_DCE_BIT = 1;
  localparam int MACH_ICE_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [2:0] MACH_RST = 3'h0;
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic [3:0] BE_HI_HALF = 4'hC;
  localparam logic [3:0] BE_LO_HALF = 4'h3;
endpackage : sx_pkg

// [sx_store_addr.sv]
`timescale 1ns/1ns
module sx_store_addr
  import sx_pkg::*;
(
  input wire logic half,
  input wire logic use_imm,
  input wire logic [0:31] base,
  input wire logic [0:31] index,
  input wire logic [0:31] imm_ext,
  input wire logic [0:31] data,
  output logic [0:31] addr,
  output logic [0:31] wdata,
  output logic [0:3] be
);
  logic [0:31] sum;

  always_comb begin
    sum = base + (use_imm ? imm_ext : index);
    if (half) begin
      addr = {sum[0:30], 1'b0};
      wdata = {data[16:31], data[16:31]};
      be = sum[30] ? BE_LO_HALF : BE_HI_HALF;
    end else begin
      addr = {sum[0:29], 2'h0};
      wdata = data;
      be = BE_ALL;
    end
  end
endmodule : sx_store_addr

// [sx_shift_xor.sv]
`timescale 1ns/1ns
module sx_shift_xor
  import sx_pkg::*;
(
  input wire sx_op_t op,
  input wire logic [0:31] a,
  input wire logic [0:31] b,
  input wire logic [0:31] imm_ext,
  input wire logic carry_in,
  output logic [0:31] res,
  output logic cout
);
  always_comb begin
    res = a ^ b;
    cout = carry_in;
    case (op)
      OP_SHIFT_ARITH: {res, cout} = {a[0], a};
      OP_SHIFT_THRU_CARRY: {res, cout} = {carry_in, a};
      OP_SHIFT_LOGIC: {res, cout} = {1'b0, a};
      OP_XOR_IMM: res = a ^ imm_ext;
      default: res = a ^ b;
    endcase
  end
endmodule : sx_shift_xor

// [sx_mem_model.sv]
`timescale 1ns/1ns
module sx_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_wr,
  input wire logic [0:31] mem_addr,
  input wire logic [0:31] mem_wdata,
  input wire logic [0:3] mem_be,
  input wire logic dcache_wr,
  input wire logic icache_wr,
  input wire logic [0:31] cache_tag,
  input wire logic cache_valid,
  input wire logic cache_lock,
  input wire logic [0:31] cache_data
);
  logic [31:0] st_addr_q;
  logic [31:0] st_data_q;
  logic [3:0] be_q;
  logic [31:0] tag_q [2];
  logic [31:0] dat_q [2];
  logic [1:0] vl_q [2];
  int n_st;
  int n_cw;

  // index 0 holds the data cache line, 1 the instruction cache line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_st <= 0;
      n_cw <= 0;
    end else begin
      if (mem_wr === 1'b1) begin
        st_addr_q <= mem_addr;
        st_data_q <= mem_wdata;
        be_q <= mem_be;
        n_st <= n_st + 1;
      end
      if (dcache_wr === 1'b1 || icache_wr === 1'b1) begin
        tag_q[icache_wr] <= cache_tag;
        dat_q[icache_wr] <= cache_data;
        vl_q[icache_wr] <= {cache_valid, cache_lock};
        n_cw <= n_cw + 1;
      end
    end
  end
endmodule : sx_mem_model

// [sx_exec_unit_bench.sv]
`timescale 1ns/1ns
module sx_exec_unit_bench;
  import sx_pkg::*;
  typedef struct {
    logic [3:0] op;
    logic [31:0] a, b, d;
    logic [15:0] imm;
    logic cin, ec;
    logic [31:0] e1, e2;
    logic [3:0] e3;
  } sx_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_wr, dcache_wr, icache_wr, cache_valid, cache_lock;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [0:31] mem_addr, mem_wdata, cache_tag, cache_data;
  logic [0:3] mem_be;
  logic erv;
  int n_mismatch = 0;
  int n_checks = 0;
  int n0, c0;
  sx_row_t r;
  // stores: e1 addr, e2 data, e3 lanes; shifts/xor: e1 result; caches: e1 tag, e2 data, e3 valid/lock
  sx_row_t rows [12] = '{
    '{4'h0, 32'h0000_1000, 32'h0000_0003, 32'hAAAA_1234, 16'h0000, 1, 1, 32'h0000_1002, 32'h1234_1234, 4'h3},
    '{4'h1, 32'h0000_2000, 32'h0, 32'h0000_BEEF, 16'hFFFC, 0, 0, 32'h0000_1FFC, 32'hBEEF_BEEF, 4'hC},
    '{4'h2, 32'h0000_0100, 32'h0000_0007, 32'hDEAD_BEEF, 16'h0000, 1, 1, 32'h0000_0104, 32'hDEAD_BEEF, 4'hF},
    '{4'h3, 32'h0000_0010, 32'h0, 32'h1234_5678, 16'h7FFF, 0, 0, 32'h0000_800C, 32'h1234_5678, 4'hF},
    '{4'h4, 32'h8000_0003, 32'h0, 32'h0, 16'h0000, 0, 1, 32'hC000_0001, 32'h0, 4'h0},
    '{4'h5, 32'h0000_0002, 32'h0, 32'h0, 16'h0000, 1, 0, 32'h8000_0001, 32'h0, 4'h0},
    '{4'h5, 32'hFFFF_FFFF, 32'h0, 32'h0, 16'h0000, 0, 1, 32'h7FFF_FFFF, 32'h0, 4'h0},
    '{4'h6, 32'h8000_0001, 32'h0, 32'h0, 16'h0000, 1, 1, 32'h4000_0000, 32'h0, 4'h0},
    '{4'h7, 32'hF0F0_0000, 32'h0FF0_FFFF, 32'h0, 16'h0000, 1, 1, 32'hFF00_FFFF, 32'h0, 4'h0},
    '{4'h8, 32'h0000_0000, 32'h0, 32'h0, 16'h8001, 0, 0, 32'hFFFF_8001, 32'h0, 4'h0},
    '{4'h9, 32'h1234_5603, 32'hCAFE_F00D, 32'h0, 16'h0000, 1, 1, 32'h1234_5603, 32'hCAFE_F00D, 4'h3},
    '{4'hA, 32'h0000_0A02, 32'h3456_789A, 32'h0, 16'h0000, 0, 0, 32'h0000_0A02, 32'h3456_789A, 4'h2}
  };

  sx_exec_unit #(.XORI_ZERO_EXT(1'b0)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .dcache_wr(dcache_wr),
    .icache_wr(icache_wr), .cache_tag(cache_tag), .cache_valid(cache_valid), .cache_lock(cache_lock),
    .cache_data(cache_data));
  sx_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .dcache_wr(dcache_wr), .icache_wr(icache_wr),
    .cache_tag(cache_tag), .cache_valid(cache_valid), .cache_lock(cache_lock), .cache_data(cache_data));

  always #10 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic xf(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) n_mismatch++;
  endtask : xf

  task automatic run(input logic [3:0] op, input logic pfx);
    int k;
    k = 0;
    xf(1'b1, OFS_CTRL, {22'h0, pfx, 1'b1, 4'h0, op});
    do begin
      xf(1'b0, OFS_STATUS, 32'h0000_0000);
      k++;
    end while (rdv[STAT_BUSY_BIT] !== 1'b0 && k < 20);
  endtask : run

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #(20 * 20000);
    n_mismatch++;
    summarize();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      xf(1'b1, OFS_FIRST, r.a);
      xf(1'b1, OFS_SECOND, r.b);
      xf(1'b1, OFS_STDATA, r.d);
      xf(1'b1, OFS_IMM, {16'h0000, r.imm});
      // caches kept disabled before any cache write
      xf(1'b1, OFS_MACH, {31'h0, r.cin});
      n0 = u_mem.n_st;
      c0 = u_mem.n_cw;
      run(r.op, 1'b0);
      xf(1'b0, OFS_MACH, 32'h0000_0000);
      chk(rdv & 32'h0000_0001, {31'h0, r.ec}); // carry out
      chk(u_mem.n_st - n0, {31'h0, r.op < 4'h4}); // one write per store
      chk(u_mem.n_cw - c0, {31'h0, r.op > 4'h8}); // one cache strobe
      if (r.op < 4'h4) begin
        chk(u_mem.st_addr_q, r.e1); // aligned address
        chk(u_mem.st_data_q, r.e2); // store data
        chk({28'h0, u_mem.be_q}, {28'h0, r.e3}); // byte lanes
      end else if (r.op < 4'h9) begin
        xf(1'b0, OFS_RESULT, 32'h0000_0000);
        chk(rdv, r.e1); // result
      end else begin
        chk(u_mem.tag_q[r.op - 4'h9], r.e1); // tag word
        chk(u_mem.dat_q[r.op - 4'h9], r.e2); // data word
        chk({30'h0, u_mem.vl_q[r.op - 4'h9]}, {28'h0, r.e3}); // valid and lock
      end
    end
    // prefix supplies the upper half for one operation only
    xf(1'b1, OFS_PREFIX, 32'h0000_1234);
    xf(1'b1, OFS_IMM, 32'h0000_8000);
    xf(1'b1, OFS_FIRST, 32'h0000_0000);
    run(4'h8, 1'b1);
    xf(1'b0, OFS_RESULT, 32'h0000_0000);
    chk(rdv, 32'h1234_8000); // prefixed operand
    xf(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rdv, 32'h0000_0008); // prefix consumed
    run(4'h8, 1'b0);
    xf(1'b0, OFS_RESULT, 32'h0000_0000);
    chk(rdv, 32'hFFFF_8000); // sign extension back
    // enabled data cache: write refused and flagged
    xf(1'b1, OFS_MACH, 32'h0000_0002);
    c0 = u_mem.n_cw;
    run(4'h9, 1'b0);
    chk(u_mem.n_cw - c0, 32'h0000_0000); // no strobe
    xf(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdv, 32'h0000_0002); // sticky error
    xf(1'b1, OFS_STATUS, 32'h0000_0002);
    xf(1'b1, OFS_MACH, 32'h0000_0000);
    run(4'hB, 1'b0);
    xf(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdv, 32'h0000_0002); // unknown code flagged
    // enabled instruction cache: write refused and flagged
    xf(1'b1, OFS_STATUS, 32'h0000_0002);
    xf(1'b1, OFS_MACH, 32'h0000_0004);
    c0 = u_mem.n_cw;
    run(4'hA, 1'b0);
    chk(u_mem.n_cw - c0, 32'h0000_0000); // no strobe
    xf(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdv, 32'h0000_0002); // refusal flagged
    xf(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0, erv}, 32'h0000_0001); // unmapped refused
    // mid-run reset, then every register back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int o = 0; o <= 32; o += 4) begin
      xf(1'b0, 8'(o), 32'h0000_0000);
      chk(rdv, WORD_RST); // reset value
    end
    summarize();
  end
endmodule : sx_exec_unit_bench
